// ==== kps_top.sv ====
// kps_top: keypad matrix scanner with extra io bit, AXI4-Lite register slave and interrupt
// assumes one 250 MHz clock; keypad and extra input pin are synchronous to it
//
// Chosen here: the AXI4-Lite slave port.
`default_nettype none
module kps_top #(
  parameter int P_SCAN_STEP_CYC = kps_pkg::SCAN_STEP_CYC,
  parameter int P_LONG_BASE_CYC = kps_pkg::LONG_BASE_CYC
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // axi4-lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [11:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // axi4-lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // axi4-lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [11:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // keypad matrix
  output logic [3:0] o_row_n,
  input wire logic [4:0] i_col_n,
  // extra io bit
  input wire logic i_extra_input_pin,
  output logic o_extra_output_pin,
  // system
  output logic o_keypad_interrupt,
  output logic o_wake
);
  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] int_ctrl;
    logic [7:0] int_status;
    logic gpo;
    logic gpi;
    logic aw_full;
    logic [9:0] aw_addr;
    logic w_full;
    logic [7:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [31:0] long_cnt;
    logic long_done;
    logic wake;
    logic irq;
  } kps_top_st_t;

  kps_top_st_t st_ff;
  kps_top_st_t nxt_st;
  kps_pkg::kps_keys_t keys;
  logic key_change;
  logic [3:0] row_n;

  // mapped only below byte address 0x400; yields index or all ones
  function automatic logic [8:0] reg_index(input logic [11:0] addr);
    return (addr[11:10] == 2'h0) ? {1'b0, addr[9:2]} : 9'h1FF;
  endfunction

  function automatic logic [31:0] long_limit(input logic [1:0] thr, input int base);
    return 32'(base) * {30'h0, thr} + 32'(base);
  endfunction

  kps_scan #(
    .P_STEP_CYC(P_SCAN_STEP_CYC)
  ) u_scan (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_enable(st_ff.ctrl1[kps_pkg::C1_SCAN_EN]),
    .i_freq(st_ff.ctrl1[2:0]),
    .i_col_n(i_col_n),
    .o_row_n(row_n),
    .o_keys(keys),
    .o_change(key_change)
  );

  always_comb begin
    logic [8:0] idx;
    logic [7:0] rd;
    logic ok;
    logic [7:0] set;
    logic [7:0] clr;
    idx = 9'h0;
    rd = 8'h00;
    ok = 1'b1;
    set = 8'h00;
    clr = 8'h00;
    nxt_st = st_ff;
    nxt_st.gpi = i_extra_input_pin;

    // write: address and data taken in either order, answered once both are held
    if (i_awvalid && st_ff.awready) begin
      nxt_st.aw_full = 1'b1;
      nxt_st.aw_addr = i_awaddr[11:2];
    end
    if (i_wvalid && st_ff.wready) begin
      nxt_st.w_full = 1'b1;
      nxt_st.wdata = i_wdata[7:0];
      nxt_st.wstrb0 = i_wstrb[0];
    end
    if (st_ff.bvalid && i_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.aw_full && st_ff.w_full && !st_ff.bvalid) begin
      nxt_st.aw_full = 1'b0;
      nxt_st.w_full = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = kps_pkg::RESP_OKAY;
      idx = reg_index({st_ff.aw_addr, 2'h0});
      // only lane 0 carries register bits; other lanes are accepted and dropped
      if (idx[8]) begin
        nxt_st.bresp = kps_pkg::RESP_SLVERR;
      end else begin
        case (idx[7:0])
          kps_pkg::IDX_CTRL_ONE: begin
            if (st_ff.wstrb0) nxt_st.ctrl1 = st_ff.wdata & kps_pkg::C1_WMASK;
          end
          kps_pkg::IDX_CTRL_TWO: begin
            if (st_ff.wstrb0) nxt_st.ctrl2 = st_ff.wdata & kps_pkg::C2_WMASK;
          end
          kps_pkg::IDX_EXTRA_IO: begin
            if (st_ff.wstrb0) nxt_st.gpo = st_ff.wdata[0];
          end
          kps_pkg::IDX_INT_CTRL: begin
            if (st_ff.wstrb0) nxt_st.int_ctrl = st_ff.wdata & kps_pkg::INT_WMASK;
          end
          kps_pkg::IDX_INT_STATUS: begin
            if (st_ff.wstrb0) clr = st_ff.wdata & kps_pkg::INT_WMASK;
          end
          kps_pkg::IDX_CODE_FIRST, kps_pkg::IDX_CODE_SECOND, kps_pkg::IDX_CODE_THIRD: begin
            nxt_st.bresp = kps_pkg::RESP_OKAY;
          end
          default: begin
            nxt_st.bresp = kps_pkg::RESP_SLVERR;
          end
        endcase
      end
    end
    nxt_st.awready = !nxt_st.aw_full;
    nxt_st.wready = !nxt_st.w_full;

    // read
    if (st_ff.rvalid && i_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (i_arvalid && st_ff.arready) begin
      idx = reg_index(i_araddr);
      case (idx)
        {1'b0, kps_pkg::IDX_CTRL_ONE}: rd = st_ff.ctrl1;
        {1'b0, kps_pkg::IDX_CTRL_TWO}: rd = {st_ff.ctrl2[7:2], keys.count};
        {1'b0, kps_pkg::IDX_CODE_FIRST}: rd = keys.code[0];
        {1'b0, kps_pkg::IDX_CODE_SECOND}: rd = keys.code[1];
        {1'b0, kps_pkg::IDX_CODE_THIRD}: rd = keys.code[2];
        {1'b0, kps_pkg::IDX_EXTRA_IO}: rd = {7'h00, st_ff.gpi};
        {1'b0, kps_pkg::IDX_INT_CTRL}: rd = st_ff.int_ctrl;
        {1'b0, kps_pkg::IDX_INT_STATUS}: rd = st_ff.int_status;
        default: ok = 1'b0;
      endcase
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd;
      nxt_st.rresp = ok ? kps_pkg::RESP_OKAY : kps_pkg::RESP_SLVERR;
    end
    nxt_st.arready = !nxt_st.rvalid;

    // long press: held unchanged key set counted in clock cycles
    if (!st_ff.ctrl1[kps_pkg::C1_LONG_EN] || key_change || keys.count == 2'h0) begin
      nxt_st.long_cnt = 32'h0;
      nxt_st.long_done = 1'b0;
    end else if (!st_ff.long_done) begin
      if (st_ff.long_cnt >= long_limit(st_ff.ctrl2[kps_pkg::C2_THR_LO +: 2], P_LONG_BASE_CYC) - 32'h1) begin
        nxt_st.long_done = 1'b1;
        set[kps_pkg::INT_LONG] = 1'b1;
      end else begin
        nxt_st.long_cnt = st_ff.long_cnt + 32'h1;
      end
    end

    set[kps_pkg::INT_KEY] = key_change;
    // wake follows any held key while enabled
    nxt_st.wake = st_ff.ctrl2[kps_pkg::C2_WAKE_EN] && keys.count != 2'h0;
    set[kps_pkg::INT_WAKE] = nxt_st.wake && !st_ff.wake;
    // a new event in the clearing cycle survives the clear
    nxt_st.int_status = (st_ff.int_status & ~clr) | set;
    // the keypad enable gates the whole output; the other mask bits only pick events
    nxt_st.irq = st_ff.int_ctrl[kps_pkg::INT_KEY] && |(nxt_st.int_status & st_ff.int_ctrl);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '{ctrl1: kps_pkg::CTRL_ONE_RST, ctrl2: kps_pkg::CTRL_TWO_RST, int_ctrl: kps_pkg::INT_RST,
                 int_status: kps_pkg::INT_RST, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_awready = st_ff.awready;
  assign o_wready = st_ff.wready;
  assign o_bvalid = st_ff.bvalid;
  assign o_bresp = st_ff.bresp;
  assign o_arready = st_ff.arready;
  assign o_rvalid = st_ff.rvalid;
  assign o_rdata = {24'h0, st_ff.rdata};
  assign o_rresp = st_ff.rresp;
  assign o_row_n = row_n;
  assign o_extra_output_pin = st_ff.gpo;
  assign o_keypad_interrupt = st_ff.irq;
  assign o_wake = st_ff.wake;

  sequence s_rd_take(logic [8:0] i);
    i_arvalid && o_arready && reg_index(i_araddr) == i;
  endsequence

  property p_irq_gate;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      ##1 o_keypad_interrupt == ($past(st_ff.int_ctrl[kps_pkg::INT_KEY]) && |($past(st_ff.int_ctrl) & st_ff.int_status));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated by enable");

  property p_count_read;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      s_rd_take({1'b0, kps_pkg::IDX_CTRL_TWO}) ##1 o_rvalid |-> o_rdata[1:0] == $past(keys.count);
  endproperty
  a_count_read: assert property (p_count_read) else $error("key count read wrong");

  property p_gpi_read;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      s_rd_take({1'b0, kps_pkg::IDX_EXTRA_IO}) ##1 o_rvalid |-> o_rdata == {31'h0, $past(i_extra_input_pin, 2)};
  endproperty
  a_gpi_read: assert property (p_gpi_read) else $error("extra io read wrong");

  property p_gpo_write;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      $rose(o_bvalid) && st_ff.aw_addr == {2'h0, kps_pkg::IDX_EXTRA_IO} && st_ff.wstrb0 && o_bresp == 2'h0
        |-> o_extra_output_pin == st_ff.wdata[0];
  endproperty
  a_gpo_write: assert property (p_gpo_write) else $error("extra output pin not written");

  property p_long_off;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      !st_ff.ctrl1[kps_pkg::C1_LONG_EN] |=> !st_ff.long_done && st_ff.long_cnt == 32'h0;
  endproperty
  a_long_off: assert property (p_long_off) else $error("long press active while disabled");

  property p_wake_off;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      !st_ff.ctrl2[kps_pkg::C2_WAKE_EN] |=> !o_wake;
  endproperty
  a_wake_off: assert property (p_wake_off) else $error("wake while disabled");

  property p_scan_idle;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      !st_ff.ctrl1[kps_pkg::C1_SCAN_EN] [*2] |-> o_row_n == 4'hF;
  endproperty
  a_scan_idle: assert property (p_scan_idle) else $error("matrix driven while scan off");

  property p_irq_off;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      !st_ff.int_ctrl[kps_pkg::INT_KEY] |=> !o_keypad_interrupt;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("keypad interrupt raised while disabled");

  property p_key_event;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      key_change |=> st_ff.int_status[kps_pkg::INT_KEY];
  endproperty
  a_key_event: assert property (p_key_event) else $error("key set change not flagged");

  property p_wake_level;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      st_ff.ctrl2[kps_pkg::C2_WAKE_EN] && keys.count != 2'h0 |=> o_wake;
  endproperty
  a_wake_level: assert property (p_wake_level) else $error("held key did not wake");
endmodule
`default_nettype wire

// ==== kps_pkg.sv ====
// kps_pkg: constants, register indices and carrier types for the keypad scanner
// assumes a 250 MHz reference clock and a 32-bit AXI4-Lite register bus
`default_nettype none
package kps_pkg;
  localparam int CLK_MHZ = 250;
  // scan cycle at code 0, whole 4x5 matrix
  localparam int SCAN_BASE_NS = 64000;
  localparam int SCAN_BASE_CYC = SCAN_BASE_NS * CLK_MHZ / 1000;
  localparam int ROWS = 4;
  localparam int COLS = 5;
  localparam int SCAN_STEP_CYC = SCAN_BASE_CYC / ROWS;
  // long-press hold at threshold code 00b
  localparam int LONG_BASE_MS = 625;
  localparam int LONG_BASE_CYC = LONG_BASE_MS * CLK_MHZ * 1000;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL_ONE = 8'hC0;
  localparam logic [7:0] IDX_CTRL_TWO = 8'hC1;
  localparam logic [7:0] IDX_CODE_FIRST = 8'hC2;
  localparam logic [7:0] IDX_CODE_SECOND = 8'hC3;
  localparam logic [7:0] IDX_CODE_THIRD = 8'hC4;
  localparam logic [7:0] IDX_EXTRA_IO = 8'hC7;
  localparam logic [7:0] IDX_INT_STATUS = 8'hC8;
  localparam logic [7:0] IDX_INT_CTRL = 8'hF0;

  // field positions
  localparam int C1_SCAN_EN = 7;
  localparam int C1_LONG_EN = 6;
  localparam int C2_WAKE_EN = 7;
  localparam int C2_THR_LO = 2;
  localparam int INT_KEY = 4;
  localparam int INT_LONG = 5;
  localparam int INT_WAKE = 6;

  // reset values, write masks and bus response codes
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] INT_RST = 8'h00;
  localparam logic [7:0] C1_WMASK = 8'hF7;
  localparam logic [7:0] C2_WMASK = 8'h8C;
  localparam logic [7:0] INT_WMASK = 8'h70;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [1:0] count;
    logic [2:0][7:0] code;
  } kps_keys_t;

  // key code: row in bits 5-4, column in bits 2-0
  function automatic logic [7:0] kps_code(input logic [1:0] row, input logic [2:0] col);
    return {2'h0, row, 1'b0, col};
  endfunction
endpackage
`default_nettype wire

// ==== kps_scan.sv ====
// kps_scan: row strobe, column sense and two-frame debounce of a 4x5 key matrix
// assumes column inputs are synchronous, pulled high, and low where a key joins the driven row
`default_nettype none
module kps_scan #(
  parameter int P_STEP_CYC = kps_pkg::SCAN_STEP_CYC
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // control
  input wire logic i_enable,
  input wire logic [2:0] i_freq,
  // matrix pins
  input wire logic [4:0] i_col_n,
  output logic [3:0] o_row_n,
  // results
  output kps_pkg::kps_keys_t o_keys,
  output logic o_change
);
  typedef enum logic {S_IDLE, S_SCAN} kps_scan_state_t;
  typedef struct packed {
    kps_scan_state_t state;
    logic [31:0] div;
    logic [1:0] row;
    kps_pkg::kps_keys_t frame;
    kps_pkg::kps_keys_t prev;
    kps_pkg::kps_keys_t keys;
    logic [3:0] row_n;
    logic change;
  } kps_scan_st_t;

  kps_scan_st_t st_ff;
  kps_scan_st_t nxt_st;
  logic [31:0] limit;

  // code doubles the scan cycle
  assign limit = 32'(P_STEP_CYC) << i_freq;

  always_comb begin
    kps_pkg::kps_keys_t f;
    f = st_ff.frame;
    nxt_st = st_ff;
    nxt_st.change = 1'b0;
    case (st_ff.state)
      S_IDLE: begin
        nxt_st.row_n = 4'hF;
        nxt_st.div = 32'h0;
        nxt_st.row = 2'h0;
        nxt_st.frame = '0;
        if (i_enable) begin
          nxt_st.state = S_SCAN;
          nxt_st.row_n = 4'hE;
        end
      end
      S_SCAN: begin
        if (!i_enable) begin
          nxt_st.state = S_IDLE;
          nxt_st.row_n = 4'hF;
        end else if (st_ff.div >= limit - 32'h1) begin
          nxt_st.div = 32'h0;
          // sample at the end of the row slot so the lines have settled
          for (int c = 0; c < kps_pkg::COLS; c++) begin
            if (!i_col_n[c] && f.count != 2'h3) begin
              f.code[f.count] = kps_pkg::kps_code(st_ff.row, 3'(c));
              f.count = f.count + 2'h1;
            end
          end
          nxt_st.row = st_ff.row + 2'h1;
          nxt_st.row_n = ~(4'h1 << nxt_st.row);
          nxt_st.frame = f;
          if (st_ff.row == 2'(kps_pkg::ROWS - 1)) begin
            // publish only a set seen twice in a row, count and codes together
            if (f == st_ff.prev && f != st_ff.keys) begin
              nxt_st.keys = f;
              nxt_st.change = 1'b1;
            end
            nxt_st.prev = f;
            nxt_st.frame = '0;
          end
        end else begin
          nxt_st.div = st_ff.div + 32'h1;
        end
      end
      default: begin
        nxt_st.state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '{state: S_IDLE, row_n: 4'hF, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_row_n = st_ff.row_n;
  assign o_keys = st_ff.keys;
  assign o_change = st_ff.change;

  property p_idle_rows;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      !i_enable |=> o_row_n == 4'hF;
  endproperty
  a_idle_rows: assert property (p_idle_rows) else $error("rows driven while scan disabled");

  property p_publish;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      o_change |-> (o_keys == st_ff.prev) && (o_keys != $past(o_keys));
  endproperty
  a_publish: assert property (p_publish) else $error("key set published without debounce");

  property p_unused_codes;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
      o_change && o_keys.count < 2'h2 |-> o_keys.code[1] == 8'h00 && o_keys.code[2] == 8'h00;
  endproperty
  a_unused_codes: assert property (p_unused_codes) else $error("stale code beyond key count");
endmodule
`default_nettype wire

// ==== kps_keypad_model.sv ====
// kps_keypad_model: behavioural 4x5 key matrix facing the scanner's row and column pins
// assumes rows are driven active low; columns carry pull-ups, so an unjoined column reads 1
`default_nettype none
module kps_keypad_model (
  // matrix pins
  input wire logic [3:0] i_row_n,
  output logic [4:0] o_col_n,
  // pressed keys, bit row*5+col
  input wire logic [19:0] i_keys
);
  always_comb begin
    for (int c = 0; c < 5; c++) begin
      o_col_n[c] = 1'b1;
      for (int r = 0; r < 4; r++) begin
        if (i_keys[r * 5 + c] && !i_row_n[r]) begin
          o_col_n[c] = 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== kps_tb.sv ====
// tb: self-checking bench for kps_top with a keypad model on the matrix pins
// assumes shortened counts: 4 cycles per row slot at code 0, 50 cycles base hold
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, row_n;
  logic [1:0] bresp, rresp, rs;
  logic [4:0] col_n;
  logic ext_in, ext_out, irq, wake;
  logic [19:0] keys;
  logic [31:0] d;
  int err_count, tests_run, cyc;
  kps_top #(.P_SCAN_STEP_CYC(4), .P_LONG_BASE_CYC(50)) kps_top_i (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
    .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid), .i_rready(rready),
    .o_rdata(rdata), .o_rresp(rresp), .o_row_n(row_n), .i_col_n(col_n), .i_extra_input_pin(ext_in),
    .o_extra_output_pin(ext_out), .o_keypad_interrupt(irq), .o_wake(wake));
  kps_keypad_model kps_keypad_model_i (.i_row_n(row_n), .o_col_n(col_n), .i_keys(keys));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // the ceiling sits well above the longest path through all scenarios
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      results();
    end
  end
  task results();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // address and data are released each at its own handshake edge
  task bus_wr(input logic [7:0] ix, input logic [7:0] v, output logic [1:0] r);
    logic a, w;
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awaddr <= {2'b00, ix, 2'b00};
    wdata <= {24'h0, v};
    a = 1'b0;
    w = 1'b0;
    while (!(a && w)) begin
      @(posedge clk);
      if (!a && awready === 1'b1) begin
        a = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task bus_rd(input logic [7:0] ix, output logic [31:0] v, output logic [1:0] r);
    @(posedge clk);
    arvalid <= 1'b1;
    rready <= 1'b1;
    araddr <= {2'b00, ix, 2'b00};
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] ix, input logic [31:0] e, input string nm);
    bus_rd(ix, d, rs);
    chk(nm, e, d);
  endtask
  task t_reset();
    chk("rows idle", 4'hF, row_n);
    rd_chk(8'hC0, 0, "ctrl one");
    rd_chk(8'hC1, 0, "ctrl two");
    rd_chk(8'hF0, 0, "irq enable");
    chk("irq", 0, irq);
    chk("wake", 0, wake);
  endtask
  task t_regs();
    bus_wr(8'hC0, 8'h3F, rs);
    rd_chk(8'hC0, 8'h37, "ctrl one rw");
    chk("rows off", 4'hF, row_n);
    bus_wr(8'hC1, 8'h7F, rs);
    rd_chk(8'hC1, 8'h0C, "ctrl two rw");
    bus_wr(8'hC7, 8'hFF, rs);
    chk("out pin", 1, ext_out);
    rd_chk(8'hC7, 0, "io low in");
    ext_in <= 1'b1;
    rd_chk(8'hC7, 1, "io high in");
    bus_wr(8'hC7, 8'h00, rs);
    chk("out pin", 0, ext_out);
    ext_in <= 1'b0;
    bus_wr(8'hC2, 8'h55, rs);
    rd_chk(8'hC2, 0, "code ro");
    bus_wr(8'hC5, 8'h55, rs);
    chk("unmapped wr", kps_pkg::RESP_SLVERR, rs);
    bus_rd(8'hC5, d, rs);
    chk("unmapped rd", kps_pkg::RESP_SLVERR, rs);
    bus_wr(8'hC1, 8'h00, rs);
  endtask
  task wait_row(output int n, output logic [3:0] p);
    p = row_n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (row_n === p && n < 2000);
  endtask
  task t_freq();
    int n;
    logic [3:0] p;
    for (int f = 0; f < 8; f++) begin
      bus_wr(8'hC0, 8'h80 | f[7:0], rs);
      repeat (2) wait_row(n, p);
      wait_row(n, p);
      chk("slot len", 4 << f, n);
      chk("row order", {p[2:0], p[3]}, row_n);
    end
    bus_wr(8'hC0, 8'h80, rs);
  endtask
  // rows 0..3 columns 0..4; a fourth key sorts last and is dropped
  task t_keys();
    logic [19:0] ks[4] = '{20'h00080, 20'h00090, 20'h08090, 20'h88090};
    logic [7:0] c0[4] = '{8'h12, 8'h04, 8'h04, 8'h04};
    logic [7:0] c1[4] = '{8'h00, 8'h12, 8'h12, 8'h12};
    logic [7:0] c2[4] = '{8'h00, 8'h00, 8'h30, 8'h30};
    keys <= 20'h00080;
    repeat (6) @(posedge clk);
    keys <= 20'h0;
    repeat (80) @(posedge clk);
    rd_chk(8'hC1, 0, "glitch count");
    for (int i = 0; i < 4; i++) begin
      keys <= ks[i];
      repeat (80) @(posedge clk);
      rd_chk(8'hC1, (i > 2) ? 3 : i + 1, "key count");
      rd_chk(8'hC2, c0[i], "code first");
      rd_chk(8'hC3, c1[i], "code second");
      rd_chk(8'hC4, c2[i], "code third");
    end
    chk("wake off", 0, wake);
  endtask
  task t_irq();
    rd_chk(8'hC8, 8'h10, "status key");
    chk("irq masked", 0, irq);
    bus_wr(8'hF0, 8'h10, rs);
    repeat (2) @(posedge clk);
    chk("irq on", 1, irq);
    bus_wr(8'hC8, 8'h10, rs);
    repeat (2) @(posedge clk);
    chk("irq cleared", 0, irq);
    bus_wr(8'hF0, 8'h00, rs);
  endtask
  task t_wake();
    bus_wr(8'hC1, 8'h80, rs);
    repeat (2) @(posedge clk);
    chk("wake on", 1, wake);
    keys <= 20'h0;
    repeat (80) @(posedge clk);
    chk("wake released", 0, wake);
    bus_wr(8'hC1, 8'h00, rs);
  endtask
  // the window allows for the write response landing a cycle or two after the enable takes hold
  task t_long();
    int n;
    keys <= 20'h00080;
    repeat (80) @(posedge clk);
    bus_wr(8'hC8, 8'h70, rs);
    bus_wr(8'hF0, 8'h30, rs);
    repeat (300) @(posedge clk);
    chk("long disabled", 0, irq);
    bus_wr(8'hF0, 8'h20, rs);
    bus_wr(8'hC0, 8'hC0, rs);
    repeat (100) @(posedge clk);
    chk("irq gated", 0, irq);
    rd_chk(8'hC8, 8'h20, "status long");
    bus_wr(8'hC0, 8'h80, rs);
    bus_wr(8'hC8, 8'h70, rs);
    bus_wr(8'hF0, 8'h30, rs);
    for (int t = 0; t < 4; t++) begin
      bus_wr(8'hC1, t[5:0] << 2, rs);
      bus_wr(8'hC0, 8'hC0, rs);
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
        @(posedge clk);
        n++;
      end
      chk("long hold", 1, (n >= (t + 1) * 50 - 3) && (n <= (t + 1) * 50 + 3));
      bus_wr(8'hC0, 8'h80, rs);
      bus_wr(8'hC8, 8'h70, rs);
    end
    keys <= 20'h0;
  endtask
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, ext_in} = '0;
    {awaddr, araddr, wdata, keys} = '0;
    wstrb = 4'hF;
    err_count = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_freq();
    t_keys();
    t_irq();
    t_wake();
    t_long();
    results();
  end
endmodule
`default_nettype wire
